// [rtl/ric_radio_irq_flags.sv]
// radio core interrupt and error flag registers with their two interrupt lines
// Behaviour
// - set rx threshold flag, low bit 2, when rx fifo count exceeds threshold
// - also set it on whole frame received or packet read with more buffered
// - set frame delimiter flag, low bit 1, when delimiter sent or received
// - set sequencer resume flag, high bit 5, on resume after wait
// - set sequencer halt flag, high bit 4, when sequencer stops its program
// - set sequencer software event flag, high bit 3, on manual interrupt
// - set radio idle flag, high bit 2, when radio enters idle
// - set transmit complete flag, high bit 1, after full frame sent
// - set ack sent flag, high bit 0, after ack frame fully sent
// - set strobe rejected flag, error bit 6, for unprocessable strobes
// - rejected: disable while disabled, ack-type command outside active reception, any other strobe while busy
// - set receive aborted flag, error bit 1, when reception is abandoned
// - set synth unlocked flag, error bit 0, on lock timeout or loss in rx
// - each flag: 0 none pending, 1 pending; all reset to 0
// - flags update regardless of mask; mask gates only the interrupt
// - events come only from rising edges of source conditions
// - clearing one flag with other unmasked flags set raises interrupt again
`timescale 1ns/10ps
module ric_radio_irq_flags
  import ric_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  // special-function register access
  input wire logic [ric_pkg::ADDR_W-1:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [ric_pkg::FLAG_W-1:0] sfr_wdata_i,
  output logic [ric_pkg::FLAG_W-1:0] sfr_rdata_o,
  // mask registers live outside this block
  input wire logic [ric_pkg::FLAG_W-1:0] mask_event_low_i,
  input wire logic [ric_pkg::FLAG_W-1:0] mask_event_high_i,
  input wire logic [ric_pkg::FLAG_W-1:0] mask_error_i,
  // receive fifo threshold sources
  input wire logic [7:0] rx_fifo_count_i,
  input wire logic [7:0] rx_fifo_threshold_i,
  input wire logic rx_frame_received_i,
  input wire logic rx_packet_read_more_i,
  // frame and sequencer sources
  input wire logic spare_event_i,
  input wire logic sfd_seen_i,
  input wire logic source_match_complete_i,
  input wire logic seq_resume_i,
  input wire logic seq_halt_i,
  input wire logic seq_software_event_i,
  input wire logic radio_idle_i,
  input wire logic tx_frame_done_i,
  input wire logic tx_ack_done_i,
  // error sources
  input wire logic strobe_valid_i,
  input wire ric_pkg::ric_strobe_t strobe_cmd_i,
  input wire logic strobe_busy_i,
  input wire logic radio_disabled_i,
  input wire logic rx_active_i,
  input wire logic rx_abort_i,
  input wire logic tx_fifo_underflow_i,
  input wire logic tx_fifo_overflow_i,
  input wire logic rx_fifo_underflow_i,
  input wire logic rx_fifo_overflow_i,
  input wire logic synth_lock_timeout_i,
  input wire logic synth_lock_lost_i,
  // flags and interrupt requests
  output logic [ric_pkg::FLAG_W-1:0] event_flags_low_o,
  output logic [ric_pkg::FLAG_W-1:0] event_flags_high_o,
  output logic [ric_pkg::FLAG_W-1:0] error_flags_o,
  output logic radio_irq_o,
  output logic radio_error_irq_o
);
  import ric_pkg::*;

  // one bundle per register bank
  ric_flag_if low_if ();
  ric_flag_if high_if ();
  ric_flag_if err_if ();

  logic strobe_reject;
  logic synth_fault;
  logic [FLAG_W-1:0] src_low;
  logic [FLAG_W-1:0] src_high;
  logic [FLAG_W-1:0] src_err;
  logic wr_low;
  logic wr_high;
  logic wr_err;
  logic pend_radio;
  logic pend_error;
  logic [FLAG_W-1:0] next_rdata;

  // interrupt request state
  logic pend_radio_q;
  logic pend_error_q;
  logic clr_radio_q;
  logic clr_error_q;
  // next values of the request state
  logic next_pend_radio;
  logic next_pend_error;
  logic next_clr_radio;
  logic next_clr_error;
  logic next_radio_irq;
  logic next_error_irq;
  logic radio_irq;
  logic error_irq;
  logic [FLAG_W-1:0] rdata;

  function automatic logic [FLAG_W-1:0] unmasked(input logic [FLAG_W-1:0] f,
                                                 input logic [FLAG_W-1:0] m);
    unmasked = f & m;
  endfunction

  function automatic logic reg_hit(input logic strobe,
                                   input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] target);
    reg_hit = strobe && (a == target);
  endfunction

  // a write counts as a clear only if it takes down a flag that stands
  function automatic logic clears_any(input logic [FLAG_W-1:0] f,
                                      input logic [FLAG_W-1:0] d);
    clears_any = |(f & ~d);
  endfunction

  // rejected strobe: a cycle pulse, so back-to-back rejects need a gap to
  // register twice through the edge detector
  always_comb
  begin
    strobe_reject = 1'b0;
    if (strobe_valid_i)
    begin
      case (strobe_cmd_i)
        STB_RADIO_OFF: strobe_reject = radio_disabled_i;
        STB_ACK, STB_ACK_PENDING, STB_NO_ACK: strobe_reject = !rx_active_i;
        default: strobe_reject = strobe_busy_i;
      endcase
    end
  end

  // lock loss only counts while receiving; a timeout counts at any time
  assign synth_fault = synth_lock_timeout_i | (synth_lock_lost_i & rx_active_i);

  always_comb
  begin
    src_low = '0;
    src_low[BIT_SPARE_EVENT] = spare_event_i;
    src_low[BIT_SFD] = sfd_seen_i;
    src_low[BIT_RX_THRESHOLD] = (rx_fifo_count_i > rx_fifo_threshold_i)
      | rx_frame_received_i | rx_packet_read_more_i;
    src_low[BIT_SOURCE_MATCH_COMPLETE_FLAG] = source_match_complete_i;

    src_high = '0;
    src_high[BIT_ACK_SENT] = tx_ack_done_i;
    src_high[BIT_TX_COMPLETE] = tx_frame_done_i;
    src_high[BIT_RADIO_IDLE] = radio_idle_i;
    src_high[BIT_SEQ_SW_EVENT] = seq_software_event_i;
    src_high[BIT_SEQ_HALT] = seq_halt_i;
    src_high[BIT_SEQ_RESUME] = seq_resume_i;

    src_err = '0;
    src_err[BIT_SYNTH_UNLOCKED] = synth_fault;
    src_err[BIT_RX_ABORTED] = rx_abort_i;
    src_err[BIT_RX_FIFO_OVERFLOW] = rx_fifo_overflow_i;
    src_err[BIT_RX_FIFO_UNDERFLOW] = rx_fifo_underflow_i;
    src_err[BIT_TX_FIFO_OVERFLOW] = tx_fifo_overflow_i;
    src_err[BIT_TX_FIFO_UNDERFLOW] = tx_fifo_underflow_i;
    src_err[BIT_STROBE_REJECTED] = strobe_reject;
  end

  // address decode of writes
  always_comb
  begin
    wr_low = 1'b0;
    wr_high = 1'b0;
    wr_err = 1'b0;
    if (reg_hit(sfr_wr_i, sfr_addr_i, ADDR_EVENT_LOW))
    begin
      wr_low = 1'b1;
    end
    else if (reg_hit(sfr_wr_i, sfr_addr_i, ADDR_EVENT_HIGH))
    begin
      wr_high = 1'b1;
    end
    else if (reg_hit(sfr_wr_i, sfr_addr_i, ADDR_ERROR))
    begin
      wr_err = 1'b1;
    end
  end

  assign low_if.src = src_low;
  assign low_if.wr = wr_low;
  assign low_if.wdata = sfr_wdata_i;
  assign high_if.src = src_high;
  assign high_if.wr = wr_high;
  assign high_if.wdata = sfr_wdata_i;
  assign err_if.src = src_err;
  assign err_if.wr = wr_err;
  assign err_if.wdata = sfr_wdata_i;

  // three identical banks; only the set of implemented bits differs
  ric_flag_bank #(.VALID(VALID_EVENT_LOW)) u_low (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .fb(low_if.bank)
  );

  ric_flag_bank #(.VALID(VALID_EVENT_HIGH)) u_high (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .fb(high_if.bank)
  );

  ric_flag_bank #(.VALID(VALID_ERROR)) u_err (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .fb(err_if.bank)
  );

  // read path: reads have no side effect; unknown addresses return zero
  always_comb
  begin
    next_rdata = rdata;
    if (reg_hit(sfr_rd_i, sfr_addr_i, ADDR_EVENT_LOW))
    begin
      next_rdata = low_if.flags;
    end
    else if (reg_hit(sfr_rd_i, sfr_addr_i, ADDR_EVENT_HIGH))
    begin
      next_rdata = high_if.flags;
    end
    else if (reg_hit(sfr_rd_i, sfr_addr_i, ADDR_ERROR))
    begin
      next_rdata = err_if.flags;
    end
    else if (sfr_rd_i)
    begin
      next_rdata = '0;
    end
  end

  // interrupt requests are one-cycle pulses toward the cpu flag bits
  always_comb
  begin
    pend_radio = |unmasked(low_if.flags, mask_event_low_i)
      | |unmasked(high_if.flags, mask_event_high_i);
    pend_error = |unmasked(err_if.flags, mask_error_i);
    // a new unmasked pending state, or a clear that leaves others standing
    next_radio_irq = pend_radio & (~pend_radio_q | clr_radio_q);
    next_error_irq = pend_error & (~pend_error_q | clr_error_q);
    next_pend_radio = pend_radio;
    next_pend_error = pend_error;
    // writing ones over standing flags must not fake a fresh request
    next_clr_radio = (wr_low & clears_any(low_if.flags, sfr_wdata_i))
      | (wr_high & clears_any(high_if.flags, sfr_wdata_i));
    next_clr_error = wr_err & clears_any(err_if.flags, sfr_wdata_i);
  end

  // request state; pulses last exactly one clock
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      pend_radio_q <= 1'b0;
      pend_error_q <= 1'b0;
      clr_radio_q <= 1'b0;
      clr_error_q <= 1'b0;
      radio_irq <= 1'b0;
      error_irq <= 1'b0;
    end
    else
    begin
      pend_radio_q <= next_pend_radio;
      pend_error_q <= next_pend_error;
      clr_radio_q <= next_clr_radio;
      clr_error_q <= next_clr_error;
      radio_irq <= next_radio_irq;
      error_irq <= next_error_irq;
    end
  end

  // read data holds between reads so a slow cpu can fetch it later
  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rdata <= FLAGS_RESET;
    end
    else
    begin
      rdata <= next_rdata;
    end
  end

  assign sfr_rdata_o = rdata;
  assign event_flags_low_o = low_if.flags;
  assign event_flags_high_o = high_if.flags;
  assign error_flags_o = err_if.flags;
  assign radio_irq_o = radio_irq;
  assign radio_error_irq_o = error_irq;
endmodule

// [shared/ric_pkg.sv]
// shared constants and types for the radio core interrupt flag block
package ric_pkg;
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned ADDR_W = 8;

  // special-function register addresses
  localparam logic [7:0] ADDR_EVENT_LOW = 8'he9;
  localparam logic [7:0] ADDR_EVENT_HIGH = 8'h91;
  localparam logic [7:0] ADDR_ERROR = 8'hbf;

  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // bits that exist in each register; the rest read zero and ignore writes
  localparam logic [7:0] VALID_EVENT_LOW = 8'h0f;
  localparam logic [7:0] VALID_EVENT_HIGH = 8'h3f;
  localparam logic [7:0] VALID_ERROR = 8'h7f;

  // low event register fields
  localparam int unsigned BIT_SPARE_EVENT = 0;
  localparam int unsigned BIT_SFD = 1;
  localparam int unsigned BIT_RX_THRESHOLD = 2;
  localparam int unsigned BIT_SOURCE_MATCH_COMPLETE_FLAG = 3;

  // high event register fields
  localparam int unsigned BIT_ACK_SENT = 0;
  localparam int unsigned BIT_TX_COMPLETE = 1;
  localparam int unsigned BIT_RADIO_IDLE = 2;
  localparam int unsigned BIT_SEQ_SW_EVENT = 3;
  localparam int unsigned BIT_SEQ_HALT = 4;
  localparam int unsigned BIT_SEQ_RESUME = 5;

  // error register fields
  localparam int unsigned BIT_SYNTH_UNLOCKED = 0;
  localparam int unsigned BIT_RX_ABORTED = 1;
  localparam int unsigned BIT_RX_FIFO_OVERFLOW = 2;
  localparam int unsigned BIT_RX_FIFO_UNDERFLOW = 3;
  localparam int unsigned BIT_TX_FIFO_OVERFLOW = 4;
  localparam int unsigned BIT_TX_FIFO_UNDERFLOW = 5;
  localparam int unsigned BIT_STROBE_REJECTED = 6;

  // command strobe classes as seen by the flag logic
  typedef enum logic [2:0] {
    STB_OTHER,
    STB_RADIO_OFF,
    STB_ACK,
    STB_ACK_PENDING,
    STB_NO_ACK
  } ric_strobe_t;
endpackage

// [shared/ric_flag_if.sv]
// bundle between the control logic and one flag register bank
`timescale 1ns/10ps
interface ric_flag_if;
  import ric_pkg::*;
  logic [FLAG_W-1:0] src;
  logic wr;
  logic [FLAG_W-1:0] wdata;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] rise;

  modport bank (input src, input wr, input wdata, output flags, output rise);
  modport ctl (output src, output wr, output wdata, input flags, input rise);
endinterface

// [rtl/ric_flag_bank.sv]
// one 8-bit sticky flag register with edge-triggered sources and write-zero clear
`timescale 1ns/10ps
module ric_flag_bank
  import ric_pkg::*;
#(
  parameter logic [7:0] VALID = 8'hff
)
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  ric_flag_if.bank fb
);
  import ric_pkg::*;

  logic [FLAG_W-1:0] src_prev;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] next_src_prev;
  logic [FLAG_W-1:0] next_flags;
  logic [FLAG_W-1:0] rise;
  logic [FLAG_W-1:0] clr;

  always_comb
  begin
    // only a 0-to-1 change of a source counts, a held level does nothing more
    rise = fb.src & ~src_prev & VALID;
    clr = fb.wr ? ~fb.wdata : '0;
    // the set term is ored last so an event in the clearing cycle survives
    next_flags = ((flags & ~clr) | rise) & VALID;
    next_src_prev = fb.src;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      src_prev <= FLAGS_RESET;
      flags <= FLAGS_RESET;
    end
    else
    begin
      src_prev <= next_src_prev;
      flags <= next_flags;
    end
  end

  assign fb.flags = flags;
  assign fb.rise = rise;
endmodule

// [sim/ric_radio_irq_flags_props.sv]
// concurrent checks on the radio flag block ports
`timescale 1ns/10ps
module ric_radio_irq_flags_props
  import ric_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] mask_error_i,
  input wire logic sfd_seen_i,
  input wire logic seq_halt_i,
  input wire logic strobe_valid_i,
  input wire ric_pkg::ric_strobe_t strobe_cmd_i,
  input wire logic rx_active_i,
  input wire logic tx_fifo_overflow_i,
  input wire logic synth_lock_lost_i,
  input wire logic [7:0] event_flags_low_o,
  input wire logic [7:0] event_flags_high_o,
  input wire logic [7:0] error_flags_o,
  input wire logic radio_error_irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  property p_sfd; $rose(sfd_seen_i) |=> event_flags_low_o[1]; endproperty
  a_sfd: assert property (p_sfd) else $error("frame delimiter flag missing");
  property p_halt; $rose(seq_halt_i) |=> event_flags_high_o[4]; endproperty
  a_halt: assert property (p_halt) else $error("halt flag missing");
  property p_rej;
    strobe_valid_i && strobe_cmd_i == STB_ACK && !rx_active_i |=> error_flags_o[6];
  endproperty
  a_rej: assert property (p_rej) else $error("ack strobe not rejected");
  property p_lock; $rose(synth_lock_lost_i) && rx_active_i |=> error_flags_o[0]; endproperty
  a_lock: assert property (p_lock) else $error("unlock flag missing");
  property p_txov; $rose(tx_fifo_overflow_i) |=> error_flags_o[4]; endproperty
  a_txov: assert property (p_txov) else $error("overflow flag missing");
  property p_rsv;
    event_flags_low_o[7:4] == 4'h0 && event_flags_high_o[7:6] == 2'h0 && !error_flags_o[7];
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit set");
  property p_rd;
    sfr_rd_i && sfr_addr_i == ADDR_EVENT_HIGH |=> sfr_rdata_o == $past(event_flags_high_o);
  endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  property p_reirq;
    sfr_wr_i && sfr_addr_i == ADDR_ERROR && |(~sfr_wdata_i & error_flags_o)
      ##1 |(error_flags_o & mask_error_i) |=> radio_error_irq_o;
  endproperty
  a_reirq: assert property (p_reirq) else $error("no repeat error irq");
endmodule

bind ric_radio_irq_flags ric_radio_irq_flags_props u_props (.clk_sys_i, .nrst_i,
  .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .mask_error_i, .sfd_seen_i,
  .seq_halt_i, .strobe_valid_i, .strobe_cmd_i, .rx_active_i, .tx_fifo_overflow_i,
  .synth_lock_lost_i, .event_flags_low_o, .event_flags_high_o, .error_flags_o,
  .radio_error_irq_o);

// [sim/ric_cpu_model.sv]
// cpu software side: one-cycle register strobes launched after a clock edge
`timescale 1ns/10ps
module ric_cpu_model
(
  input wire logic clk_sys_i,
  input wire logic [7:0] sfr_rdata_i,
  output logic [7:0] sfr_addr_o,
  output logic sfr_wr_o,
  output logic sfr_rd_o,
  output logic [7:0] sfr_wdata_o
);
  initial {sfr_addr_o, sfr_wr_o, sfr_rd_o, sfr_wdata_o} = 18'h0;
  // zero bits clear, one bits keep; bus shows inverted values once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    {sfr_addr_o, sfr_wdata_o, sfr_wr_o} = {a, d, 1'b1};
    @(posedge clk_sys_i) #1;
    {sfr_addr_o, sfr_wdata_o, sfr_wr_o} = {~a, ~d, 1'b0};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i) #1;
    {sfr_addr_o, sfr_rd_o} = {a, 1'b1};
    @(posedge clk_sys_i) #1;
    {sfr_addr_o, sfr_rd_o} = {~a, 1'b0};
    d = sfr_rdata_i;
  endtask
endmodule

// [sim/ric_radio_irq_flags_tb.sv]
// self-checking bench for the radio flag block
`timescale 1ns/10ps
module ric_radio_irq_flags_tb;
  import ric_pkg::*;
  localparam logic [7:0] AD [3] = '{ADDR_EVENT_LOW, ADDR_EVENT_HIGH, ADDR_ERROR};
  logic clk_sys_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [23:0] src = 24'h0;
  logic [7:0] cnt = 8'h00, thr = 8'h00, mh = 8'hff, mask_error_i = 8'hff;
  logic rpm = 1'b0, lost = 1'b0, busy = 1'b0, dis = 1'b0, rx_active_i = 1'b0;
  logic strobe_valid_i = 1'b0;
  ric_strobe_t strobe_cmd_i = STB_OTHER;
  logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, low, high, err;
  logic sfr_wr_i, sfr_rd_i, irq, eirq;
  int errors = 0, n_compared = 0, irq_n = 0, eirq_n = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  ric_cpu_model cpu (.clk_sys_i, .sfr_rdata_i(sfr_rdata_o), .sfr_addr_o(sfr_addr_i),
    .sfr_wr_o(sfr_wr_i), .sfr_rd_o(sfr_rd_i), .sfr_wdata_o(sfr_wdata_i));
  ric_radio_irq_flags dut (.clk_sys_i, .nrst_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
    .sfr_wdata_i, .sfr_rdata_o, .mask_event_low_i(8'hff), .mask_event_high_i(mh),
    .mask_error_i, .rx_fifo_count_i(cnt), .rx_fifo_threshold_i(thr),
    .rx_frame_received_i(src[2]), .rx_packet_read_more_i(rpm), .spare_event_i(src[0]),
    .sfd_seen_i(src[1]), .source_match_complete_i(src[3]), .seq_resume_i(src[13]),
    .seq_halt_i(src[12]), .seq_software_event_i(src[11]), .radio_idle_i(src[10]),
    .tx_frame_done_i(src[9]), .tx_ack_done_i(src[8]), .strobe_valid_i, .strobe_cmd_i,
    .strobe_busy_i(busy), .radio_disabled_i(dis), .rx_active_i, .rx_abort_i(src[17]),
    .tx_fifo_underflow_i(src[21]), .tx_fifo_overflow_i(src[20]),
    .rx_fifo_underflow_i(src[19]), .rx_fifo_overflow_i(src[18]),
    .synth_lock_timeout_i(src[16]), .synth_lock_lost_i(lost), .event_flags_low_o(low),
    .event_flags_high_o(high), .error_flags_o(err), .radio_irq_o(irq),
    .radio_error_irq_o(eirq));
  always @(posedge clk_sys_i)
  begin
    if (irq === 1'b1) irq_n++;
    if (eirq === 1'b1) eirq_n++;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    cpu.rd(a, v);
    chk(v, e);
  endtask
  task automatic t_src();
    logic [7:0] v [3] = '{VALID_EVENT_LOW, VALID_EVENT_HIGH, 8'h3f};
    for (int g = 0; g < 3; g++)
      for (int b = 0; b < 8; b++)
        if (v[g][b])
        begin
          src[g*8+b] = 1'b1;
          cyc(2);
          rdc(AD[g], 8'h01 << b);
          chk(g == 0 ? low : (g == 1 ? high : err), 8'h01 << b);
          cpu.wr(AD[g], ~(8'h01 << b));
          cyc(2);
          rdc(AD[g], 8'h00);
          src[g*8+b] = 1'b0;
          cyc(1);
        end
    $display("sources done");
  endtask
  task automatic t_stb(input ric_strobe_t c, input logic di, ra, bz, input logic [7:0] e);
    strobe_cmd_i = c;
    dis = di;
    rx_active_i = ra;
    busy = bz;
    strobe_valid_i = 1'b1;
    cyc(1);
    strobe_valid_i = 1'b0;
    rdc(AD[2], e);
    cpu.wr(AD[2], 8'h00);
    cyc(1);
  endtask
  task automatic t_reset();
    for (int g = 0; g < 3; g++) rdc(AD[g], 8'h00);
    cpu.wr(8'h55, 8'h00);
    rdc(8'h55, 8'h00);
    cpu.wr(AD[1], 8'hff);
    rdc(AD[1], 8'h00);
    $display("reset and reserved done");
  endtask
  task automatic t_thr();
    cnt = 8'h05;
    thr = 8'h05;
    cyc(3);
    rdc(AD[0], 8'h00);
    cnt = 8'h06;
    cyc(3);
    rdc(AD[0], 8'h04);
    cnt = 8'h00;
    cpu.wr(AD[0], 8'hfb);
    rpm = 1'b1;
    cyc(3);
    rdc(AD[0], 8'h04);
    rpm = 1'b0;
    cpu.wr(AD[0], 8'h00);
    $display("threshold done");
  endtask
  task automatic t_strobes();
    for (int i = 2; i < 5; i++)
    begin
      t_stb(ric_strobe_t'(i), 1'b0, 1'b0, 1'b0, 8'h40);
      t_stb(ric_strobe_t'(i), 1'b0, 1'b1, 1'b0, 8'h00);
    end
    t_stb(STB_RADIO_OFF, 1'b1, 1'b1, 1'b0, 8'h40);
    t_stb(STB_RADIO_OFF, 1'b0, 1'b1, 1'b0, 8'h00);
    t_stb(STB_OTHER, 1'b0, 1'b1, 1'b1, 8'h40);
    t_stb(STB_OTHER, 1'b0, 1'b1, 1'b0, 8'h00);
    $display("strobes done");
  endtask
  task automatic t_lock();
    lost = 1'b1;
    cyc(2);
    rdc(AD[2], 8'h01);
    cpu.wr(AD[2], 8'hfe);
    rdc(AD[2], 8'h00);
    // lock still lost: only a receiver restart brings the flag back
    rx_active_i = 1'b0;
    cyc(2);
    rx_active_i = 1'b1;
    cyc(2);
    rdc(AD[2], 8'h01);
    lost = 1'b0;
    cpu.wr(AD[2], 8'h00);
    $display("lock done");
  endtask
  task automatic t_irq();
    mh = 8'h02;
    irq_n = 0;
    src[8] = 1'b1;
    cyc(4);
    chk(irq_n[7:0], 8'h00);
    rdc(AD[1], 8'h01);
    src[9] = 1'b1;
    cyc(4);
    chk(irq_n[7:0], 8'h01);
    cpu.wr(AD[1], 8'hfd);
    cyc(3);
    chk(irq_n[7:0], 8'h01);
    rdc(AD[1], 8'h01);
    src[20] = 1'b1;
    src[18] = 1'b1;
    cyc(4);
    eirq_n = 0;
    cpu.wr(AD[2], 8'hef);
    cyc(3);
    chk(eirq_n[7:0], 8'h01);
    $display("irq done");
  endtask
  initial
  begin
    cyc(2);
    nrst_i = 1'b1;
    t_reset();
    t_src();
    t_thr();
    t_strobes();
    t_lock();
    t_irq();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    errors++;
    test_done();
  end
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
